// file: include/safeguard_muting_controller_regs.vh
// Constants for the safeguard muting controller
// Behaviour
// RQ1: Protective stop open forces both outputs off
// RQ2: Active mute ignores muteable stop, outputs on
// RQ3: Unmuted muteable stop open turns outputs off
// RQ4: Output short fault forces outputs off
// RQ5: Status mirror output shown on green indicator
// RQ6: Feedback check: one-channel, two-channel or none
// RQ7: One-channel: reset needs feedback contact closed
// RQ8: One-channel: feedback closed 200 ms after off
// RQ9: Two-channel: both closed before outputs on
// RQ10: Two-channel: disagreement over 200 ms locks out
// RQ11: Two-channel: both closed 200 ms after off
// RQ12: Installer links terminals to disable checking
// RQ13: Mute needs pair within 3 s
// RQ14: Mute starts and ends from one pair
// RQ15: Permit closed to start; opening later ignored
// RQ16: Permit cycle with one sensor restarts timer
// RQ17: Permit closed >1/4 s, open 1/4..2 s
// RQ18: Restart once per cycle, rearm all open
// RQ19: Mute lamp driven while muted, monitored optionally
// RQ20: Monitored lamp failure blocks new mutes
// RQ21: Lockout: outputs off, red flashes, error shown
// RQ22: Manual reset: closed 1/4 s to 2 s, reopen
// RQ23: Lockout recovery always needs manual reset
// RQ24: All windows timed by common millisecond tick
`ifndef SAFEGUARD_MUTING_CONTROLLER_REGS_VH
`define SAFEGUARD_MUTING_CONTROLLER_REGS_VH
`define CLK_HZ        40000000
`define TICK_MS       1
`define TICK_CYCLES   (`CLK_HZ / 1000 * `TICK_MS)
`define SIM_MS        12'd3000
`define FB_MS         12'd200
`define RST_MIN_MS    12'd250
`define PERMIT_MIN_MS 12'd251
`define GEST_MAX_MS   12'd2000
`define BLINK_BIT     8
`define ADDR_CTRL     8'h00
`define ADDR_STAT     8'h04
`define CTRL_RESET    4'h0
`define CTRL_MANUAL   0
`define CTRL_FB_LO    1
`define CTRL_FB_HI    2
`define CTRL_LAMPMON  3
`define FB_NONE       2'h0
`define FB_ONE        2'h1
`define FB_TWO        2'h2
`define ERR_NONE      8'h00
`define ERR_FB_OFF    8'h01
`define ERR_FB_DIS    8'h02
`define ERR_SHORT     8'h03
`endif

// file: rtl/safeguard_muting_controller.v
// Safeguard muting controller with APB configuration and status
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "safeguard_muting_controller_regs.vh"

// Timed level gesture: pulse when an active phase ends inside its window
module gesture_detector #(
  parameter [0:0]  ACT    = 1'b1,
  parameter [11:0] PRE_MS = 12'd0,
  parameter [11:0] MIN_MS = 12'd250,
  parameter [11:0] MAX_MS = 12'd2000
) (
  // Clock and control
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        tick,
  // Level and result
  input  wire        level_in,
  output reg         pulse_r
);
  reg        lvl_r;
  reg [11:0] cnt_r;
  reg        pre_ok_r;

  // Phase length counter saturates so a stuck input never wraps
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lvl_r    <= 1'b0;
      cnt_r    <= 12'h000;
      pre_ok_r <= 1'b0;
      pulse_r  <= 1'b0;
    end
    else if (ce)
    begin
      pulse_r <= 1'b0;
      lvl_r   <= level_in;
      if (level_in != lvl_r)
      begin
        cnt_r <= 12'h000;
        if (lvl_r == ACT)
        begin
          // Active phase ends: judge its length (see RQ17) (see RQ22)
          pulse_r  <= pre_ok_r && (cnt_r >= MIN_MS) && (cnt_r <= MAX_MS);
          pre_ok_r <= 1'b0;
        end
        else
          pre_ok_r <= (cnt_r >= PRE_MS);
      end
      else if (tick && (cnt_r != 12'hfff))
        cnt_r <= cnt_r + 12'h001;
    end
  end
endmodule // gesture_detector

module safeguard_muting_controller #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // Clock, reset and enable
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Safety inputs, high means closed; output_short_fault high means a short is present
  input  wire        muteable_stop_input,
  input  wire        protective_stop_input,
  input  wire        manual_reset_input,
  input  wire        output_short_fault,
  // Contactor feedback, high means closed
  input  wire        contactor_feedback_a,
  input  wire        contactor_feedback_b,
  // Mute sensors and permit, high means closed
  input  wire        mute_sensor_one,
  input  wire        mute_sensor_two,
  input  wire        mute_sensor_three,
  input  wire        mute_sensor_four,
  input  wire        mute_permit,
  input  wire        lamp_current_fault,
  // Outputs
  output reg         switched_safety_output_a,
  output reg         switched_safety_output_b,
  output reg         status_mirror,
  output reg         green_led,
  output reg         red_led,
  output reg         mute_indicator_lamp,
  output reg  [7:0]  error_code
);
  localparam [1:0] ST_OFF  = 2'd0;
  localparam [1:0] ST_ON   = 2'd1;
  localparam [1:0] ST_LOCK = 2'd2;

  reg  [15:0] tick_cnt_r;
  reg         tick_r;
  reg  [3:0]  ctrl_r;
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [7:0]  err_r;
  reg  [7:0]  err_nxt;
  reg         fbw_r;
  reg  [11:0] fbw_cnt_r;
  reg  [11:0] dis_cnt_r;
  reg  [11:0] sim_cnt_r [0:1];
  reg         muted_r;
  reg         muted_nxt;
  reg         restart_used_r;
  reg         lamp_fail_r;
  reg  [8:0]  blink_r;
  wire        rst_pulse;
  wire        permit_pulse;
  wire        manual;
  wire [1:0]  fb_mode;
  wire        lamp_mon;
  wire        fb_closed;
  wire        fb_late;
  wire        fb_dis;
  wire [1:0]  pair_both;
  wire [1:0]  pair_one;
  wire [1:0]  pair_ok;
  wire        all_open;
  wire        restart_go;
  wire        mute_start;
  wire        apb_wr;
  integer     i;

  assign manual   = ctrl_r[`CTRL_MANUAL];
  assign fb_mode  = ctrl_r[`CTRL_FB_HI:`CTRL_FB_LO];
  assign lamp_mon = ctrl_r[`CTRL_LAMPMON];

  // Common millisecond tick; every window counts these (see RQ24)
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_r <= 16'h0000;
      tick_r     <= 1'b0;
    end
    else if (clk_en)
    begin
      tick_r <= (tick_cnt_r == TICK_CYCLES[15:0] - 16'h0001);
      if (tick_cnt_r == TICK_CYCLES[15:0] - 16'h0001)
        tick_cnt_r <= 16'h0000;
      else
        tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end

  // Manual reset gesture: closed 1/4 s to 2 s, then reopened
  gesture_detector #(
    .ACT    (1'b1),
    .PRE_MS (12'd0),
    .MIN_MS (`RST_MIN_MS),
    .MAX_MS (`GEST_MAX_MS)
  ) u_reset_gesture (
    .clk      (pclk),
    .rst_n    (presetn),
    .ce       (clk_en),
    .tick     (tick_r),
    .level_in (manual_reset_input),
    .pulse_r  (rst_pulse)
  );

  // Permit gesture: the open phase and the closed phase before it are both timed
  gesture_detector #(
    .ACT    (1'b1),
    .PRE_MS (`PERMIT_MIN_MS),
    .MIN_MS (`PERMIT_MIN_MS),
    .MAX_MS (`GEST_MAX_MS)
  ) u_permit_gesture (
    .clk      (pclk),
    .rst_n    (presetn),
    .ce       (clk_en),
    .tick     (tick_r),
    .level_in (~mute_permit),
    .pulse_r  (permit_pulse)
  );

  // Feedback closed per selected mode (see RQ6) (see RQ7) (see RQ9)
  assign fb_closed = (fb_mode == `FB_ONE) ? contactor_feedback_a :
                     (fb_mode == `FB_TWO) ? (contactor_feedback_a & contactor_feedback_b) :
                     1'b1;
  // Still open when the post-off window expires (see RQ8) (see RQ11)
  assign fb_late = fbw_r && (fbw_cnt_r >= `FB_MS) && !fb_closed;
  // Channels disagree too long while on (see RQ10)
  assign fb_dis  = (dis_cnt_r > `FB_MS);

  // Sensor pairs
  assign pair_both[0] = mute_sensor_one & mute_sensor_two;
  assign pair_both[1] = mute_sensor_three & mute_sensor_four;
  assign pair_one[0]  = mute_sensor_one ^ mute_sensor_two;
  assign pair_one[1]  = mute_sensor_three ^ mute_sensor_four;
  assign all_open     = ~(mute_sensor_one | mute_sensor_two |
                          mute_sensor_three | mute_sensor_four);
  // Counter freezes once both close, so a late pair never mutes (see RQ13)
  assign pair_ok[0]   = pair_both[0] && (sim_cnt_r[0] < `SIM_MS);
  assign pair_ok[1]   = pair_both[1] && (sim_cnt_r[1] < `SIM_MS);
  // One restart per cycle, only with a lone sensor active (see RQ16) (see RQ18)
  assign restart_go   = permit_pulse && !restart_used_r && (pair_one != 2'b00);
  // Permit and a healthy lamp are needed only at the start (see RQ15) (see RQ20)
  assign mute_start   = !muted_r && (state_r == ST_ON) && mute_permit &&
                        !(lamp_mon && lamp_fail_r) && (pair_ok != 2'b00);

  // Main state decision
  always @*
  begin
    state_nxt = state_r;
    err_nxt   = err_r;
    case (state_r)
      ST_ON:
      begin
        if (output_short_fault)
        begin
          state_nxt = ST_LOCK; // see RQ4
          err_nxt   = `ERR_SHORT;
        end
        else if (fb_dis)
        begin
          state_nxt = ST_LOCK; // see RQ10
          err_nxt   = `ERR_FB_DIS;
        end
        else if (!protective_stop_input)
          state_nxt = ST_OFF; // see RQ1
        else if (!muteable_stop_input && !muted_r)
          state_nxt = ST_OFF; // see RQ2 see RQ3
      end
      ST_OFF:
      begin
        if (output_short_fault)
        begin
          state_nxt = ST_LOCK; // see RQ4
          err_nxt   = `ERR_SHORT;
        end
        else if (fb_late)
        begin
          state_nxt = ST_LOCK; // see RQ8 see RQ11
          err_nxt   = `ERR_FB_OFF;
        end
        else if (protective_stop_input && muteable_stop_input && fb_closed &&
                 (!manual || rst_pulse))
          state_nxt = ST_ON; // see RQ7 see RQ9
      end
      ST_LOCK:
      begin
        // Automatic mode still needs the gesture here (see RQ23)
        if (rst_pulse && !output_short_fault)
        begin
          state_nxt = ST_OFF;
          err_nxt   = `ERR_NONE;
        end
      end
      default:
      begin
        state_nxt = ST_LOCK;
        err_nxt   = `ERR_SHORT;
      end
    endcase
  end

  // Mute ends when neither pair is fully made or the outputs drop (see RQ14)
  always @*
  begin
    muted_nxt = muted_r;
    if (state_nxt != ST_ON)
      muted_nxt = 1'b0;
    else if (mute_start)
      muted_nxt = 1'b1; // see RQ13
    else if (muted_r && (pair_both == 2'b00))
      muted_nxt = 1'b0; // see RQ14
  end

  // State, feedback and mute registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r        <= ST_OFF;
      err_r          <= `ERR_NONE;
      fbw_r          <= 1'b0;
      fbw_cnt_r      <= 12'h000;
      dis_cnt_r      <= 12'h000;
      muted_r        <= 1'b0;
      restart_used_r <= 1'b0;
      lamp_fail_r    <= 1'b0;
      blink_r        <= 9'h000;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      err_r   <= err_nxt;
      muted_r <= muted_nxt;
      if (tick_r)
        blink_r <= blink_r + 9'h001;
      // Outputs on->off opens the feedback window (see RQ8) (see RQ11)
      if ((state_r == ST_ON) && (state_nxt != ST_ON))
      begin
        fbw_r     <= 1'b1;
        fbw_cnt_r <= 12'h000;
      end
      else if (fb_closed || (state_r == ST_LOCK))
        fbw_r <= 1'b0;
      else if (fbw_r && tick_r && (fbw_cnt_r != 12'hfff))
        fbw_cnt_r <= fbw_cnt_r + 12'h001;
      // Feedback ignored while on in one-channel mode (see RQ8)
      if ((state_r == ST_ON) && (fb_mode == `FB_TWO) &&
          (contactor_feedback_a != contactor_feedback_b))
      begin
        if (tick_r && (dis_cnt_r != 12'hfff))
          dis_cnt_r <= dis_cnt_r + 12'h001;
      end
      else
        dis_cnt_r <= 12'h000; // see RQ10
      // Restart token: set wins over the all-open rearm (see RQ18)
      if (restart_go)
        restart_used_r <= 1'b1;
      else if (all_open)
        restart_used_r <= 1'b0;
      // Lamp fault latch; set wins over the clear (see RQ20)
      if (lamp_mon && mute_indicator_lamp && lamp_current_fault)
        lamp_fail_r <= 1'b1;
      else if (rst_pulse)
        lamp_fail_r <= 1'b0;
    end
  end

  // Simultaneity timers, one per pair
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sim_cnt_r[0] <= 12'h000;
      sim_cnt_r[1] <= 12'h000;
    end
    else if (clk_en)
    begin
      for (i = 0; i < 2; i = i + 1)
      begin
        if (!pair_one[i] && !pair_both[i])
          sim_cnt_r[i] <= 12'h000;
        else if (restart_go)
          sim_cnt_r[i] <= 12'h000; // see RQ16
        else if (pair_one[i] && tick_r && (sim_cnt_r[i] != 12'hfff))
          sim_cnt_r[i] <= sim_cnt_r[i] + 12'h001; // see RQ13
      end
    end
  end

  // Registered outputs follow the next state so they track without lag
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      switched_safety_output_a <= 1'b0;
      switched_safety_output_b <= 1'b0;
      status_mirror            <= 1'b0;
      green_led                <= 1'b0;
      red_led                  <= 1'b1;
      mute_indicator_lamp      <= 1'b0;
      error_code               <= `ERR_NONE;
    end
    else if (clk_en)
    begin
      switched_safety_output_a <= (state_nxt == ST_ON); // see RQ1 see RQ21
      switched_safety_output_b <= (state_nxt == ST_ON); // see RQ1 see RQ21
      status_mirror            <= (state_nxt == ST_ON); // see RQ5
      green_led                <= (state_nxt == ST_ON); // see RQ5
      // Red flashes in lockout, steady while simply off (see RQ21)
      red_led                  <= (state_nxt == ST_LOCK) ? blink_r[`BLINK_BIT] :
                                  (state_nxt == ST_OFF);
      mute_indicator_lamp      <= muted_nxt; // see RQ19
      error_code               <= err_nxt; // see RQ21
    end
  end

  // APB: one wait-free access phase, ready raised from the setup cycle
  assign apb_wr = psel && penable && pready && pwrite;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      ctrl_r  <= `CTRL_RESET;
    end
    else if (clk_en)
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable)
      begin
        case (paddr)
          `ADDR_CTRL:
            prdata <= pwrite ? 32'h0000_0000 : {28'h000_0000, ctrl_r};
          `ADDR_STAT:
            prdata <= pwrite ? 32'h0000_0000 :
                      {16'h0000, err_r, 3'b000, lamp_fail_r, restart_used_r,
                       muted_r, (state_r == ST_LOCK), (state_r == ST_ON)};
          default:
            pslverr <= 1'b1;
        endcase
      end
      // Mode bits are software-steered (see RQ6) (see RQ19)
      if (apb_wr && (paddr == `ADDR_CTRL))
        ctrl_r <= pwdata[3:0];
    end
  end
endmodule // safeguard_muting_controller

// file: test/contactor_lamp_model.sv
// Contactor and mute lamp model for the muting controller bench
`timescale 1ns/1ps
module contactor_lamp_model #(
  parameter int DLY = 8
) (
  // Coil drive from the safety outputs, lamp drive
  input  wire logic pclk,
  input  wire logic drive_a,
  input  wire logic drive_b,
  input  wire logic lamp_on,
  // Fault injection
  input  wire logic stuck_b,
  input  wire logic weld_a,
  input  wire logic link,
  input  wire logic broken,
  // Feedback to the controller
  output logic      fb_a,
  output logic      fb_b,
  output logic      lamp_fault
);
  logic [DLY-1:0] arm_a_r = '0;
  logic [DLY-1:0] arm_b_r = '0;

  // Armatures lag the coil drive, so feedback is never instant
  always @(posedge pclk)
  begin
    arm_a_r <= {arm_a_r[DLY-2:0], drive_a};
    arm_b_r <= {arm_b_r[DLY-2:0], drive_b};
  end

  // Monitor contacts close when released; a welded main contact keeps its monitor open
  assign fb_a = !(arm_a_r[DLY-1] | weld_a);
  assign fb_b = link ? fb_a : (stuck_b | !arm_b_r[DLY-1]);
  // Current is out of range only while a broken lamp is lit
  assign lamp_fault = lamp_on & broken;
endmodule // contactor_lamp_model

// file: test/safeguard_muting_controller_checker.sv
// Port-level assertions for the safeguard muting controller
`timescale 1ns/1ps
module safeguard_muting_checker (
  // Clock, reset and APB
  input wire       pclk,
  input wire       presetn,
  input wire       clk_en,
  input wire       psel,
  input wire       penable,
  input wire       pready,
  input wire       pslverr,
  // Safety inputs
  input wire       muteable_stop_input,
  input wire       protective_stop_input,
  input wire       output_short_fault,
  // Outputs
  input wire       switched_safety_output_a,
  input wire       switched_safety_output_b,
  input wire       status_mirror,
  input wire       green_led,
  input wire       mute_indicator_lamp,
  input wire [7:0] error_code
);
  wire on_a = switched_safety_output_a;
  wire on_b = switched_safety_output_b;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Stop causes are seen at one edge and act at that edge
  a_stop_off: assert property (clk_en && !protective_stop_input |=> !on_a && !on_b)
    else $error("outputs on after protective stop");
  a_short_off: assert property (clk_en && output_short_fault |=> !on_a && !on_b)
    else $error("outputs on with short fault");
  a_unmuted_off: assert property (clk_en && !muteable_stop_input && !mute_indicator_lamp
    |=> !on_a) else $error("unmuted stop left outputs on");
  a_muted_on: assert property (mute_indicator_lamp |-> on_a && on_b)
    else $error("muted but outputs off");
  a_pair_equal: assert property (on_a == on_b)
    else $error("safety outputs disagree");
  a_mirror_green: assert property (status_mirror == on_a && green_led == on_a)
    else $error("mirror or green differs from outputs");
  a_lock_off: assert property (error_code != 8'h00 |-> !on_a && !mute_indicator_lamp)
    else $error("outputs on during lockout");
  // Bus answers once, one cycle after setup
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_one: assert property (pready |-> (psel && penable) ##1 !pready)
    else $error("ready outside one access cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule // safeguard_muting_checker

bind safeguard_muting_controller safeguard_muting_checker u_chk (
  .pclk, .presetn, .clk_en, .psel, .penable, .pready, .pslverr,
  .muteable_stop_input, .protective_stop_input, .output_short_fault,
  .switched_safety_output_a, .switched_safety_output_b, .status_mirror,
  .green_led, .mute_indicator_lamp, .error_code
);

// file: test/safeguard_muting_controller_test.sv
// Self-checking bench for the safeguard muting controller
`timescale 1ns/1ps
`include "safeguard_muting_controller_regs.vh"
module safeguard_muting_controller_test;
  // Short tick keeps multi-second windows affordable
  localparam int TK = 4;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic        pready, pslverr, e, oa, ob, mir, grn, red, lamp;
  logic        mss = 1, pss = 1, rst_in = 0, short = 0, permit = 1;
  logic        s1 = 0, s2 = 0, s3 = 0, s4 = 0, stuck = 0, broken = 0;
  logic        weld = 0, ce = 1;
  logic [7:0]  err;
  wire         fa, fb, lfault;
  int          n_errors = 0, checked = 0;

  always #12.5 pclk = ~pclk;

  safeguard_muting_controller #(.TICK_CYCLES(TK)) DUT (
    .pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .muteable_stop_input(mss),
    .protective_stop_input(pss), .manual_reset_input(rst_in),
    .output_short_fault(short), .contactor_feedback_a(fa), .contactor_feedback_b(fb),
    .mute_sensor_one(s1), .mute_sensor_two(s2), .mute_sensor_three(s3),
    .mute_sensor_four(s4), .mute_permit(permit), .lamp_current_fault(lfault),
    .switched_safety_output_a(oa), .switched_safety_output_b(ob),
    .status_mirror(mir), .green_led(grn), .red_led(red),
    .mute_indicator_lamp(lamp), .error_code(err));

  contactor_lamp_model #(.DLY(8)) partner (.pclk(pclk), .drive_a(oa), .drive_b(ob),
    .lamp_on(lamp), .stuck_b(stuck), .weld_a(weld), .link(1'h0), .broken(broken),
    .fb_a(fa), .fb_b(fb), .lamp_fault(lfault));

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic ms(input int n);
    cyc(n * TK);
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex)
    begin
      $display("BAD %s expected %h seen %h", nm, ex, got);
      n_errors++;
    end
  endtask

  task automatic finish_test;
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One APB transfer; entered just after an edge, leaves one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic rdy;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 16);
    // Remember whether the answer came; ready has already dropped one edge later
    rdy = pready;
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    if (rdy !== 1'h1)
    begin
      n_errors++;
      finish_test;
    end
  endtask

  // Reset button pressed for a given time, then released
  task automatic press(input int t);
    rst_in <= 1;
    ms(t);
    rst_in <= 0;
    cyc(4);
  endtask

  initial
  begin
    cyc(5);
    presetn <= 1;
    cyc(3);
    chk("on after reset", 1'h1, oa);
    chk("red while on", 1'h0, red);
    // Clock enable low freezes the stop response until it returns
    ce <= 0;
    pss <= 0;
    cyc(8);
    chk("frozen outputs", 1'h1, oa);
    ce <= 1;
    cyc(2);
    chk("thawed stop", 1'h0, oa);
    pss <= 1;
    cyc(2);
    apb(0, `ADDR_CTRL, 0);
    chk("ctrl reset", 0, q);
    apb(1, `ADDR_CTRL, 32'h0000_0004);
    apb(0, `ADDR_CTRL, 0);
    chk("ctrl two channel", 32'h0000_0004, q);
    apb(0, 8'h10, 0);
    chk("unmapped error", 1'h1, e);
    apb(1, `ADDR_CTRL, 0);
    // Late partner: second sensor after the window
    s1 <= 1;
    ms(3100);
    s2 <= 1;
    cyc(3);
    chk("late pair", 1'h0, lamp);
    s1 <= 0;
    s2 <= 0;
    // Permit cycle with one sensor waiting restarts the window
    s3 <= 1;
    ms(3100);
    permit <= 0;
    ms(500);
    permit <= 1;
    ms(10);
    s4 <= 1;
    cyc(3);
    chk("restart mute", 1'h1, lamp);
    permit <= 0;
    mss <= 0;
    ms(5);
    chk("permit open in mute", 1'h1, lamp);
    chk("muted stop ignored", 1'h1, oa);
    s4 <= 0;
    cyc(3);
    chk("mute end", 1'h0, lamp);
    chk("unmuted stop", 1'h0, oa);
    s3 <= 0;
    mss <= 1;
    cyc(3);
    s1 <= 1;
    s2 <= 1;
    cyc(3);
    chk("no permit", 1'h0, lamp);
    s1 <= 0;
    s2 <= 0;
    permit <= 1;
    cyc(3);
    s1 <= 1;
    ms(100);
    s2 <= 1;
    cyc(3);
    chk("pair mute", 1'h1, lamp);
    pss <= 0;
    cyc(3);
    chk("protective in mute", 1'h0, oa);
    chk("red while off", 1'h1, red);
    s1 <= 0;
    s2 <= 0;
    pss <= 1;
    cyc(3);
    // Two-channel: disagreement beyond the window locks out
    apb(1, `ADDR_CTRL, 32'h0000_0004);
    stuck <= 1;
    ms(150);
    chk("disagree early", 1'h1, oa);
    ms(60);
    chk("disagree code", 8'h02, err);
    chk("lockout off", 1'h0, oa);
    // Exactly 256 ticks flip the blink bit once
    q = red;
    ms(256);
    chk("red blinks", !q[0], red);
    stuck <= 0;
    press(100);
    chk("short press", 8'h02, err);
    press(500);
    chk("recovered", 1'h1, oa);
    short <= 1;
    cyc(3);
    chk("short off", 1'h0, oa);
    chk("short code", 8'h03, err);
    short <= 0;
    press(500);
    chk("short recovered", 1'h1, oa);
    // Monitored lamp failure blocks the next mute
    apb(1, `ADDR_CTRL, 32'h0000_0008);
    broken <= 1;
    s1 <= 1;
    s2 <= 1;
    cyc(6);
    s1 <= 0;
    s2 <= 0;
    cyc(3);
    s1 <= 1;
    s2 <= 1;
    cyc(3);
    chk("lamp fail blocks", 1'h0, lamp);
    // Manual reset with one-channel feedback and a welded contactor
    s1 <= 0;
    s2 <= 0;
    apb(1, `ADDR_CTRL, 32'h0000_0003);
    weld <= 1;
    ms(10);
    chk("weld ignored on", 1'h1, oa);
    pss <= 0;
    ms(150);
    chk("fb window", 8'h00, err);
    ms(60);
    chk("fb late code", 8'h01, err);
    pss <= 1;
    weld <= 0;
    press(500);
    chk("manual after lock", 1'h0, oa);
    weld <= 1;
    press(500);
    chk("weld refuses", 1'h0, oa);
    weld <= 0;
    press(500);
    chk("manual reset on", 1'h1, oa);
    finish_test;
  end
endmodule // safeguard_muting_controller_test
